// file: rtl/acs_sequencer.sv
// Conversion timing sequencer: oscillator model, modulator clock, decimator and ready timing.
`timescale 1ns/1ps
module acs_sequencer (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire acs_pkg::acs_cfg_t      cfg_i,
  input  wire logic                   start_cmd_i,
  input  wire logic                   result_read_i,
  input  wire logic                   mod_bit_i,
  output logic                        osc_clk_o,
  output logic                        mod_clk_o,
  output logic                        data_ready_n_o,
  output logic                        busy_o,
  output logic [acs_pkg::RES_W-1:0]   result_o
);
  import acs_pkg::*;

  // ****************************************************************
  // Oscillator model and modulator divider
  // ****************************************************************
  logic [NCO_W-1:0] nco_r;
  logic             ht_r;
  logic [2:0]       div_r;
  logic [NCO_W-1:0] nco_inc;
  logic [NCO_W:0]   nco_sum;
  logic             mod_rise;

  // The oscillator is approximated by a phase accumulator, so a half cycle
  // jitters by one master clock; long term rate is exact to the increment.
  assign nco_inc  = cfg_i.double_rate ? NCO_INC_DOUBLE : NCO_INC_NORMAL;
  assign nco_sum  = {1'b0, nco_r} + {1'b0, nco_inc};
  assign mod_rise = ht_r && (div_r == MOD_RISE_AT);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      nco_r     <= '0;
      ht_r      <= 1'b0;
      div_r     <= 3'h0;
      osc_clk_o <= 1'b0;
      mod_clk_o <= 1'b0;
    end
    else
    begin
      nco_r     <= nco_sum[NCO_W-1:0];
      ht_r      <= nco_sum[NCO_W];
      if (ht_r)
      begin
        div_r     <= (div_r == MOD_HALF_LAST) ? 3'h0 : div_r + 3'h1;
        osc_clk_o <= ~osc_clk_o;
      end
      mod_clk_o <= div_r[2];
    end
  end

  // ****************************************************************
  // Conversion sequencing
  // ****************************************************************
  acs_state_t       state_r;
  acs_state_t       state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [RES_W-1:0] acc_r;
  logic [CNT_W-1:0] period_half;
  logic [CNT_W-1:0] single_half;
  logic [CNT_W-1:0] lat_half;
  logic             last_tick;
  logic             done;
  logic             pre_done;

  assign period_half = acs_period_half(cfg_i.rate_sel);
  assign single_half = acs_single_half(cfg_i.rate_sel, cfg_i.double_rate);
  assign lat_half    = cfg_i.double_rate ? LAT_HALF_DOUBLE : LAT_HALF_NORMAL;
  assign last_tick   = ht_r && (cnt_r == 18'h00001);
  assign done        = (state_r == ACS_CONVERT) && last_tick;
  assign pre_done    = (state_r == ACS_CONVERT) && ht_r && (cnt_r == 18'h00002);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    // Counting only on oscillator half ticks keeps every period locked to it.
    if (ht_r && (cnt_r != '0))
    begin
      cnt_nxt = cnt_r - 18'h00001;
    end
    if (start_cmd_i)
    begin
      // A start during a conversion restarts it, which is the sync behaviour.
      if (cfg_i.single_shot)
      begin
        state_nxt = ACS_CONVERT;
        cnt_nxt   = single_half;
      end
      else
      begin
        state_nxt = ACS_LATENCY;
        cnt_nxt   = lat_half;
      end
    end
    else
    begin
      case (state_r)
        ACS_LATENCY:
        begin
          if (last_tick)
          begin
            state_nxt = ACS_CONVERT;
            cnt_nxt   = period_half;
          end
        end
        ACS_CONVERT:
        begin
          if (done)
          begin
            state_nxt = cfg_i.single_shot ? ACS_IDLE : ACS_CONVERT;
            cnt_nxt   = cfg_i.single_shot ? '0 : period_half;
          end
        end
        ACS_IDLE:
        begin
          state_nxt = ACS_IDLE;
        end
        default:
        begin
          state_nxt = ACS_IDLE;
        end
      endcase
    end
  end

  logic conv_start;
  assign conv_start = start_cmd_i || (state_r == ACS_LATENCY && last_tick) || done;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r        <= ACS_IDLE;
      cnt_r          <= '0;
      acc_r          <= '0;
      result_o       <= '0;
      data_ready_n_o <= 1'b1;
      busy_o         <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      busy_o  <= (state_nxt != ACS_IDLE);
      // A boxcar over exactly one conversion is a linear phase FIR that is
      // fully settled at every result; it trades noise shaping for area.
      if (conv_start)
      begin
        acc_r <= '0;
      end
      else if (mod_rise && mod_bit_i)
      begin
        acc_r <= acc_r + 16'h0001;
      end
      if (done)
      begin
        result_o <= acc_r;
      end
      if (done)
      begin
        data_ready_n_o <= 1'b0;
      end
      else if (result_read_i || pre_done)
      begin
        data_ready_n_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_mod_div;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $changed(mod_clk_o) |-> $past(ht_r, 2) && (div_r[1:0] == 2'b00);
  endproperty
  a_mod_div: assert property (p_mod_div) else $error("modulator clock off divide");

  property p_osc_normal;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ht_r && !cfg_i.double_rate |=> !ht_r [*3];
  endproperty
  a_osc_normal: assert property (p_osc_normal) else $error("normal rate too fast");

  property p_osc_double;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ht_r |=> !ht_r ##[1:4] ht_r;
  endproperty
  a_osc_double: assert property (p_osc_double) else $error("half tick too fast");

  property p_settle;
    @(posedge mclk_i) disable iff (!rst_n_i)
      done |=> (result_o == $past(acc_r)) && (acc_r == 16'h0000);
  endproperty
  a_settle: assert property (p_settle) else $error("result not from one conversion");

  property p_count_osc;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !ht_r && !start_cmd_i |=> $stable(cnt_r);
  endproperty
  a_count_osc: assert property (p_count_osc) else $error("count moved without tick");

  property p_cont_reload;
    @(posedge mclk_i) disable iff (!rst_n_i)
      done && !cfg_i.single_shot && !start_cmd_i |=>
        (cnt_r == $past(period_half)) && !data_ready_n_o;
  endproperty
  a_cont_reload: assert property (p_cont_reload) else $error("period reload wrong");

  property p_latency;
    @(posedge mclk_i) disable iff (!rst_n_i)
      start_cmd_i && !cfg_i.single_shot |=>
        state_r == ACS_LATENCY && cnt_r == (cfg_i.double_rate ? 18'h000d2 : 18'h00039);
  endproperty
  a_latency: assert property (p_latency) else $error("start latency wrong");

  property p_single;
    @(posedge mclk_i) disable iff (!rst_n_i)
      start_cmd_i && cfg_i.single_shot &&
      (cfg_i.rate_sel == 3'h0 || cfg_i.rate_sel == 3'h6) |=>
        cnt_r == ((cfg_i.rate_sel == 3'h0) ? (cfg_i.double_rate ? 18'h19022 : 18'h1901a)
                                           : (cfg_i.double_rate ? 18'h00852 : 18'h0084a));
  endproperty
  a_single: assert property (p_single) else $error("single shot time wrong");

  property p_latch;
    @(posedge mclk_i) disable iff (!rst_n_i)
      start_cmd_i |=> busy_o && state_r != ACS_IDLE;
  endproperty
  a_latch: assert property (p_latch) else $error("start command not taken");

  property p_period_tab;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_r == ACS_LATENCY && last_tick && !start_cmd_i && cfg_i.rate_sel == 3'h6 |=>
        cnt_r == 18'h00818;
  endproperty
  a_period_tab: assert property (p_period_tab) else $error("period table wrong");

  property p_single_tab;
    @(posedge mclk_i) disable iff (!rst_n_i)
      start_cmd_i && cfg_i.single_shot &&
      (cfg_i.rate_sel == 3'h3 || cfg_i.rate_sel == 3'h5) |=>
        cnt_r == ((cfg_i.rate_sel == 3'h3) ? (cfg_i.double_rate ? 18'h02e72 : 18'h02e6a)
                                           : (cfg_i.double_rate ? 18'h00db2 : 18'h00daa));
  endproperty
  a_single_tab: assert property (p_single_tab) else $error("single table wrong");

  property p_hold_low;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !data_ready_n_o && !result_read_i && !pre_done |=> !data_ready_n_o;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("ready released early");

endmodule : acs_sequencer

// file: rtl/acs_pkg.sv
// Package of constants, types and timing tables for the conversion timing sequencer.
package acs_pkg;

  // ****************************************************************
  // Clock and oscillator constants
  // ****************************************************************
  localparam longint MCLK_HZ       = 64'd10000000;
  localparam longint OSC_NORMAL_HZ = 64'd1024000;
  localparam longint OSC_DOUBLE_HZ = 64'd2048000;
  localparam int     NCO_W         = 24;
  // Half oscillator cycles are counted so that the 28.5 cycle latency is exact.
  localparam logic [NCO_W-1:0] NCO_INC_NORMAL =
    NCO_W'((2 * OSC_NORMAL_HZ * (64'd1 << NCO_W)) / MCLK_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_DOUBLE =
    NCO_W'((2 * OSC_DOUBLE_HZ * (64'd1 << NCO_W)) / MCLK_HZ);
  localparam int     MOD_DIV       = 4;
  localparam logic [2:0] MOD_HALF_LAST = 3'((2 * MOD_DIV) - 1);
  localparam logic [2:0] MOD_RISE_AT   = 3'(MOD_DIV - 1);

  // ****************************************************************
  // Timing in half oscillator cycles
  // ****************************************************************
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] LAT_HALF_NORMAL = 18'h00039;
  localparam logic [CNT_W-1:0] LAT_HALF_DOUBLE = 18'h000d2;
  localparam int RES_W = 16;

  typedef struct packed {
    logic       double_rate;
    logic       single_shot;
    logic [2:0] rate_sel;
  } acs_cfg_t;

  typedef enum logic [1:0] {ACS_IDLE, ACS_LATENCY, ACS_CONVERT} acs_state_t;

  function automatic logic [CNT_W-1:0] acs_period_half(input logic [2:0] rate);
    logic [CNT_W-1:0] p;
    p = 18'h00000;
    case (rate)
      3'h0:    p = 18'h0c7f8;
      3'h1:    p = 18'h058fc;
      3'h2:    p = 18'h02d0c;
      3'h3:    p = 18'h0171c;
      3'h4:    p = 18'h00c2c;
      3'h5:    p = 18'h006bc;
      default: p = 18'h0040c;
    endcase
    return CNT_W'({p, 1'b0});
  endfunction : acs_period_half

  function automatic logic [CNT_W-1:0] acs_single_half(input logic [2:0] rate,
                                                        input logic       dbl);
    logic [CNT_W-1:0] s;
    s = 18'h00000;
    case (rate)
      3'h0:    s = dbl ? 18'h0c811 : 18'h0c80d;
      3'h1:    s = dbl ? 18'h05919 : 18'h05915;
      3'h2:    s = dbl ? 18'h02d29 : 18'h02d25;
      3'h3:    s = dbl ? 18'h01739 : 18'h01735;
      3'h4:    s = dbl ? 18'h00c49 : 18'h00c45;
      3'h5:    s = dbl ? 18'h006d9 : 18'h006d5;
      default: s = dbl ? 18'h00429 : 18'h00425;
    endcase
    return CNT_W'({s, 1'b0});
  endfunction : acs_single_half

endpackage : acs_pkg

// file: tb/acs_host_model.sv
// Host model that issues latched start commands and result reads toward the sequencer.
`timescale 1ns/1ps
module acs_host_model (
  input  wire logic mclk_i,
  output logic      start_cmd_o,
  output logic      result_read_o
);
  // ****************************************************************
  // Command and read issue
  // ****************************************************************
  longint t_start;
  initial
  begin
    start_cmd_o   = 1'b0;
    result_read_o = 1'b0;
    t_start       = 0;
  end
  // The taking edge stands for the eighth falling clock edge of the byte, so it is the origin.
  task automatic send_start();
    @(posedge mclk_i);
    start_cmd_o <= 1'b1;
    @(posedge mclk_i);
    t_start = $time;
    start_cmd_o <= 1'b0;
  endtask : send_start
  task automatic read_result();
    @(posedge mclk_i);
    result_read_o <= 1'b1;
    @(posedge mclk_i);
    result_read_o <= 1'b0;
  endtask : read_result
endmodule : acs_host_model

// file: tb/testbench.sv
// Self-checking testbench for the conversion timing sequencer.
`timescale 1ns/1ps
module testbench;
  import acs_pkg::*;
  logic             mclk_i, rst_n_i, mod_bit, start_cmd, result_read;
  logic             osc_clk, mod_clk, rdy_n, busy;
  logic [RES_W-1:0] result;
  acs_cfg_t         cfg;
  int               err_count, checks_done, osc_n, mod_n, o0, m0;
  longint           t0, t1;
  acs_sequencer dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .start_cmd_i(start_cmd),
    .result_read_i(result_read), .mod_bit_i(mod_bit), .osc_clk_o(osc_clk), .mod_clk_o(mod_clk),
    .data_ready_n_o(rdy_n), .busy_o(busy), .result_o(result));
  acs_host_model host (.mclk_i(mclk_i), .start_cmd_o(start_cmd), .result_read_o(result_read));
  // ****************************************************************
  // Clock, edge counters and helpers
  // ****************************************************************
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge osc_clk) osc_n++;
  always @(posedge mod_clk) mod_n++;
  // Times are in ns; x2 counts half oscillator cycles so the 28.5 cycle latency stays exact.
  function automatic longint osc_ns(input longint x2, input logic dbl);
    return dbl ? x2 * 15625 / 64 : x2 * 15625 / 32;
  endfunction : osc_ns
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input int tol,
                     input string msg);
    checks_done++;
    if ((^seen === 1'bx) || (seen + tol < exp) || (seen > exp + tol))
    begin
      err_count++;
      $display("[FAIL] %0t ns %s: seen %0d expected %0d", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("TB: checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Configuration may only change while idle, so each scenario starts from a reset.
  task automatic do_reset(input acs_cfg_t c, input logic mb);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    cfg     <= c;
    mod_bit <= mb;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk(rdy_n, 1, 0, "ready idles high");
    chk(busy, 0, 0, "busy idles low");
  endtask : do_reset
  // Falls are sampled on the falling clock edge, half a period after the launching edge.
  task automatic wait_fall(output longint t);
    logic p;
    p = rdy_n;
    t = 0;
    for (int i = 0; i < 60000; i++)
    begin
      @(negedge mclk_i);
      if (p === 1'b1 && rdy_n === 1'b0)
      begin
        t = $time - 50;
        return;
      end
      p = rdy_n;
    end
    chk(0, 1, 0, "ready edge missing");
  endtask : wait_fall
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_cont_normal();
    do_reset('{1'b0, 1'b0, 3'h6}, 1'b1);
    host.send_start();
    repeat (3000) @(posedge mclk_i);
    host.send_start();
    @(negedge mclk_i);
    chk(busy, 1, 0, "busy after start");
    wait_fall(t0);
    o0 = osc_n;
    m0 = mod_n;
    chk(32'(t0 - host.t_start), 32'(osc_ns(2129, 1'b0)), 1000, "first result");
    repeat (100) @(negedge mclk_i);
    chk(rdy_n, 0, 0, "ready held until read");
    wait_fall(t1);
    chk(32'(t1 - t0), 32'(osc_ns(2072, 1'b0)), 250, "continuous period");
    chk(osc_n - o0, 1036, 1, "oscillator cycles per result");
    chk(mod_n - m0, 259, 1, "modulator cycles per result");
    chk(result, 259, 1, "ones over one conversion");
    host.read_result();
    @(negedge mclk_i);
    chk(rdy_n, 1, 0, "ready released by read");
  endtask : sc_cont_normal
  task automatic sc_cont_double();
    do_reset('{1'b1, 1'b0, 3'h5}, 1'b1);
    host.send_start();
    wait_fall(t0);
    o0 = osc_n;
    m0 = mod_n;
    chk(32'(t0 - host.t_start), 32'(osc_ns(3658, 1'b1)), 500, "first result");
    host.read_result();
    @(negedge mclk_i);
    chk(rdy_n, 1, 0, "prompt read releases ready");
    wait_fall(t1);
    chk(32'(t1 - t0), 32'(osc_ns(3448, 1'b1)), 250, "continuous period");
    chk(osc_n - o0, 1724, 1, "oscillator cycles per result");
    chk(mod_n - m0, 431, 1, "modulator cycles per result");
    chk(result, 431, 1, "ones over one conversion");
  endtask : sc_cont_double
  task automatic sc_single(input acs_cfg_t c, input longint x2, input int tol);
    do_reset(c, 1'b0);
    host.send_start();
    wait_fall(t0);
    chk(32'(t0 - host.t_start), 32'(osc_ns(x2, c.double_rate)), tol, "single time");
    chk(result, 0, 0, "no ones counted");
    repeat (2) @(negedge mclk_i);
    chk(busy, 0, 0, "busy ends after single shot");
    host.read_result();
    @(negedge mclk_i);
    chk(rdy_n, 1, 0, "ready released by read");
  endtask : sc_single
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    cfg         = '0;
    mod_bit     = 1'b0;
    rst_n_i     = 1'b0;
    err_count   = 0;
    checks_done = 0;
    osc_n       = 0;
    mod_n       = 0;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    sc_cont_normal();
    sc_cont_double();
    sc_single('{1'b0, 1'b1, 3'h6}, 2122, 1000);
    sc_single('{1'b1, 1'b1, 3'h5}, 3506, 500);
    test_done();
  end
  // The scenarios need about 60000 cycles; this limit leaves margin for slow starts.
  initial
  begin
    #(80000 * 100);
    err_count++;
    $display("[FAIL] %0t ns watchdog expired", $time);
    test_done();
  end
endmodule : testbench
